//--- dv/spr_host_model.sv
// Host side serial controller model that frames commands on the link.
`timescale 1ns/1ps

module spr_host_model (
    input  wire logic i_clk_sys, // System clock, paces the link.
    input  wire logic i_so,      // Serial data from the device.
    input  wire logic i_so_oe,   // Device drives serial out.
    output logic      o_cs_n,    // Select, active low.
    output logic      o_sck,     // Link clock, parked low.
    output logic      o_si       // Serial data to the device.
);
    // ==========================================================
    // Idle link: clock parked low between frames, select released.
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end

    // ==========================================================
    // One frame: ntx bits from tx, most significant first, then nrx
    // bits captured. Each link half period is eight system clocks, so
    // read data has settled well before it is sampled. The select
    // rises only after the last bit, so a wrong count is how a
    // scenario commands a badly timed frame.
    task automatic frame(input logic [31:0] tx, input int ntx,
                         input int nrx, output logic [31:0] rx,
                         output logic saw_oe);
        int i;
        rx = '0;
        saw_oe = 1'b0;
        @(negedge i_clk_sys);
        o_cs_n = 1'b0;
        for (i = 0; i < ntx + nrx; i++) begin
            o_sck = 1'b0;
            // Past the command the line toggles so no stale bit hangs.
            o_si = (i < ntx) ? tx[31-i] : ~o_si;
            repeat (8) @(negedge i_clk_sys);
            if (i >= ntx) begin
                rx = {rx[30:0], i_so};
                saw_oe = saw_oe | i_so_oe;
            end
            o_sck = 1'b1;
            repeat (8) @(negedge i_clk_sys);
        end
        o_sck = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        o_cs_n = 1'b1;
        repeat (16) @(negedge i_clk_sys);
    endtask
endmodule

//--- dv/tb_top.sv
// Self-checking testbench for the sector protection command block.
`timescale 1ns/1ps

module tb_top;
    logic        i_clk_sys;
    logic        i_reset_n;
    logic        i_clk_en;
    logic        i_quad_mode;
    logic [7:0]  i_lock_reg;
    logic        i_suspend;
    logic [5:0]  i_sel;
    logic        cs_n;
    logic        sck;
    logic        si;
    logic        so;
    logic        so_oe;
    logic [31:0] rx;
    logic        oe;
    logic        saw_zero;
    logic        saw_entry0;
    int          fails;
    int          checked;

    spr_cmd #(.SECTORS(64)) u_dut (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
        .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_quad_mode(i_quad_mode),
        .i_lock_reg(i_lock_reg), .i_suspend(i_suspend), .i_sel(i_sel),
        .o_so(so), .o_so_oe(so_oe), .o_write_enable_latch(),
        .o_write_in_progress(), .o_suspend_refused(), .o_prot_mode(),
        .o_prot_bits(), .o_prot_entry());

    spr_host_model u_host (
        .i_clk_sys(i_clk_sys), .i_so(so), .i_so_oe(so_oe),
        .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

    // ==========================================================
    // Clock at 250 MHz.
    always #2 i_clk_sys = ~i_clk_sys;

    // Compare one value and count it.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op, input logic [15:0] dat,
                       input int ntx, input int nrx);
        u_host.frame({op, dat, 8'h00}, ntx, nrx, rx, oe);
    endtask

    // Wait for busy to drop, bounded; note the interim array state.
    task automatic wait_idle();
        int n;
        saw_zero = 1'b0;
        saw_entry0 = 1'b0;
        for (n = 0; n < 3000 && u_dut.o_write_in_progress !== 1'b0; n++) begin
            @(negedge i_clk_sys);
            if (u_dut.o_prot_bits === 64'h0000_0000_0000_0000) saw_zero = 1;
            if (u_dut.o_prot_entry === 8'h00) saw_entry0 = 1'b1;
        end
        check(u_dut.o_write_in_progress, 1'b0);
        // Latch, mode and array ports trail the busy flag by a cycle.
        repeat (2) @(negedge i_clk_sys);
    endtask

    // ==========================================================
    // Reset values, and no refusal pulse while idle.
    task automatic t_reset();
        check(u_dut.o_prot_mode, 16'hFFFF);
        check(u_dut.o_prot_bits, 64'hFFFF_FFFF_FFFF_FFFF);
        check(u_dut.o_prot_entry, 8'hFF);
        check({u_dut.o_write_enable_latch, u_dut.o_write_in_progress}, 0);
        check(so_oe, 1'b0);
        i_suspend = 1'b1;
        @(negedge i_clk_sys);
        i_suspend = 1'b0;
        check(u_dut.o_suspend_refused, 1'b0);
    endtask

    // Protected writes without the latch change nothing.
    task automatic t_no_latch();
        cmd(spr_pkg::OP_PROG_MODE, 16'h1234, 24, 0);
        check(u_dut.o_write_in_progress, 1'b0);
        cmd(spr_pkg::OP_ERASE_PROT, 16'h0000, 8, 0);
        check(u_dut.o_write_in_progress, 1'b0);
        repeat (300) @(negedge i_clk_sys);
        check(u_dut.o_prot_mode, 16'hFFFF);
    endtask

    // Mode program: short frame discarded, full frame programs.
    task automatic t_program();
        cmd(spr_pkg::OP_WRITE_ENABLE, 16'h0000, 8, 0);
        check(u_dut.o_write_enable_latch, 1'b1);
        cmd(spr_pkg::OP_PROG_MODE, 16'h3CA5, 23, 0);
        repeat (300) @(negedge i_clk_sys);
        check(u_dut.o_prot_mode, 16'hFFFF);
        check(u_dut.o_write_enable_latch, 1'b1);
        cmd(spr_pkg::OP_PROG_MODE, 16'h3CA5, 24, 0);
        cmd(spr_pkg::OP_READ_STATUS, 16'h0000, 8, 8);
        check(rx[1:0], 2'b11);
        wait_idle();
        check(u_dut.o_write_enable_latch, 1'b0);
        check(u_dut.o_prot_mode, 16'hA53C);
    endtask

    // Mode read repeats low byte then high byte.
    task automatic t_read_mode();
        cmd(spr_pkg::OP_READ_MODE, 16'h0000, 8, 32);
        check(rx, 32'h3CA5_3CA5);
        check(oe, 1'b1);
    endtask

    // Erase: wrong select timing, then a real erase with suspend.
    task automatic t_erase();
        cmd(spr_pkg::OP_WRITE_ENABLE, 16'h0000, 8, 0);
        cmd(spr_pkg::OP_ERASE_PROT, 16'h0000, 9, 0);
        check(u_dut.o_write_in_progress, 1'b0);
        cmd(spr_pkg::OP_ERASE_PROT, 16'h0000, 8, 0);
        check(u_dut.o_write_in_progress, 1'b1);
        i_suspend = 1'b1;
        @(negedge i_clk_sys);
        i_suspend = 1'b0;
        check(u_dut.o_suspend_refused, 1'b1);
        cmd(spr_pkg::OP_READ_LOCK, 16'h0000, 8, 8);
        check(oe, 1'b0);
        wait_idle();
        check(saw_zero, 1'b1);
        check(saw_entry0, 1'b1);
        check(u_dut.o_prot_bits, 64'hFFFF_FFFF_FFFF_FFFF);
        check(u_dut.o_write_enable_latch, 1'b0);
        i_sel = 6'h05;
        repeat (3) @(negedge i_clk_sys);
        check(u_dut.o_prot_entry, 8'hFF);
    endtask

    // Lock read when idle repeats; refused in quad command mode.
    task automatic t_lock();
        cmd(spr_pkg::OP_READ_LOCK, 16'h0000, 8, 16);
        check(rx[15:0], 16'h5A5A);
        check(oe, 1'b1);
        i_quad_mode = 1'b1;
        cmd(spr_pkg::OP_READ_LOCK, 16'h0000, 8, 8);
        check(oe, 1'b0);
        i_quad_mode = 1'b0;
    endtask

    // ==========================================================
    // Main sequence; the link waits well past reset release.
    initial begin
        i_clk_sys = 1'b0;
        i_reset_n = 1'b0;
        i_clk_en = 1'b1;
        i_quad_mode = 1'b0;
        i_lock_reg = 8'h5A;
        i_suspend = 1'b0;
        i_sel = 6'h00;
        fails = 0;
        checked = 0;
        repeat (16) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        t_reset();
        t_no_latch();
        t_program();
        t_read_mode();
        t_erase();
        t_lock();
        summarize();
    end

    // Watchdog: the sequence needs roughly a seventh of this span.
    initial begin
        repeat (40000) @(posedge i_clk_sys);
        fails++;
        summarize();
    end
endmodule

//--- logic/spr_cmd.sv
// Command interpreter for the sector protection registers.
`timescale 1ns/1ps

module spr_cmd #(
    parameter int SECTORS = 64
) (
    input  wire logic                       i_clk_sys,   // System clock.
    input  wire logic                       i_reset_n,   // Sync reset.
    input  wire logic                       i_clk_en,    // Clock enable.
    input  wire logic                       i_cs_n,      // Select pin.
    input  wire logic                       i_sck,       // Serial clock.
    input  wire logic                       i_si,        // Serial in.
    input  wire logic                       i_quad_mode, // Quad mode.
    input  wire logic [7:0]                 i_lock_reg,  // Lock value.
    input  wire logic                       i_suspend,   // Suspend req.
    input  wire logic [$clog2(SECTORS)-1:0] i_sel,       // Entry index.
    output logic                            o_so,        // Serial out.
    output logic                            o_so_oe,     // Out enable.
    output logic                            o_write_enable_latch, // Latch.
    output logic                            o_write_in_progress,  // Busy.
    output logic                            o_suspend_refused,    // Pulse.
    output logic [15:0]                     o_prot_mode, // Mode reg.
    output logic [SECTORS-1:0]              o_prot_bits, // Bit array.
    output logic [7:0]                      o_prot_entry // Entry byte.
);

    // ==========================================================
    // Elaboration check.
    if (SECTORS < 2) begin : g_bad_sectors
        $error("SECTORS must be at least 2");
    end

    // Maps one protection bit onto its readback byte.
    function automatic logic [7:0] entry_code(input logic bit_val);
        entry_code = bit_val ? spr_pkg::ENTRY_UNPROT : spr_pkg::ENTRY_PROT;
    endfunction

    // ==========================================================
    // Pin synchronisation and edge detection.
    logic [2:0] pins_s;
    logic       cs_n_s;
    logic       sck_s;
    logic       si_s;
    logic       sck_d_reg;
    logic       cs_d_reg;

    spr_sync #(
        .WIDTH (3)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_cs_n, i_sck, i_si}),
        .i_init    (3'h7),
        .o_sync    (pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sck_s  = pins_s[1];
    assign si_s   = pins_s[0];

    // Edges are only honoured inside a frame; the link clock may idle.
    wire sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
    wire sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
    wire cs_rise  = cs_n_s & ~cs_d_reg;
    wire cs_fall  = ~cs_n_s & cs_d_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            sck_d_reg <= 1'b1;
            cs_d_reg  <= 1'b1;
        end else if (i_clk_en) begin
            sck_d_reg <= sck_s;
            cs_d_reg  <= cs_n_s;
        end
    end

    // ==========================================================
    // Receive side: bit counter, opcode and data shifters.
    logic [4:0]  cnt_reg;
    logic [7:0]  rx_reg;
    logic [7:0]  opcode_reg;
    logic [15:0] data_reg;

    wire in_opcode   = (cnt_reg < spr_pkg::CNT_OPCODE);
    wire last_op_bit = (cnt_reg == spr_pkg::CNT_OPCODE - 5'h01);
    wire [7:0] op_now = {rx_reg[6:0], si_s};

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cnt_reg    <= 5'h00;
            rx_reg     <= 8'h00;
            opcode_reg <= 8'h00;
            data_reg   <= 16'h0000;
        end else if (i_clk_en) begin
            if (cs_fall) begin
                cnt_reg <= 5'h00;
            end else if (sck_rise) begin
                if (cnt_reg != spr_pkg::CNT_MAX) begin
                    cnt_reg <= cnt_reg + 5'h01;
                end
                if (in_opcode) begin
                    rx_reg <= op_now;
                end else begin
                    data_reg <= {data_reg[14:0], si_s};
                end
                if (last_op_bit) begin
                    opcode_reg <= op_now;
                end
            end
        end
    end

    // ==========================================================
    // Operation state and its decoded controls.
    spr_pkg::spr_state_t state_reg;
    spr_pkg::spr_state_t state_next;
    logic [spr_pkg::TIMER_W-1:0] timer_reg;
    logic [spr_pkg::TIMER_W-1:0] timer_next;
    logic        wel_reg;
    logic [15:0] mode_reg;
    logic [15:0] pend_reg;
    logic [SECTORS-1:0] bits_reg;

    wire idle      = (state_reg == spr_pkg::ST_IDLE);
    wire op8       = (cnt_reg == spr_pkg::CNT_OPCODE);
    wire op24      = (cnt_reg == spr_pkg::CNT_PROG);
    wire end_ok    = cs_rise & idle;
    wire timer_end = (timer_reg == '0);
    wire write_enable_cmd_go   = end_ok & op8 &
                     (opcode_reg == spr_pkg::OP_WRITE_ENABLE);
    wire erase_go  = end_ok & op8 & wel_reg &
                     (opcode_reg == spr_pkg::OP_ERASE_PROT);
    wire prog_go   = end_ok & op24 & wel_reg &
                     (opcode_reg == spr_pkg::OP_PROG_MODE);
    wire erasing   = (state_reg == spr_pkg::ST_PREPROG) |
                     (state_reg == spr_pkg::ST_ERASE);
    // Only the last phase ends the operation; the pre-program step of an
    // erase must not drop the latch while the array is still being worked.
    wire op_done   = ~idle & timer_end &
                     (state_next == spr_pkg::ST_IDLE);

    // Erase runs pre-program then erase; program is a single phase.
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg - spr_pkg::TIMER_ONE;
        case (state_reg)
            spr_pkg::ST_IDLE: begin
                timer_next = timer_reg;
                if (erase_go) begin
                    state_next = spr_pkg::ST_PREPROG;
                    timer_next = spr_pkg::PREPROG_CYC - spr_pkg::TIMER_ONE;
                end else if (prog_go) begin
                    state_next = spr_pkg::ST_PROGRAM;
                    timer_next = spr_pkg::PROG_CYC - spr_pkg::TIMER_ONE;
                end
            end
            spr_pkg::ST_PREPROG: begin
                if (timer_end) begin
                    state_next = spr_pkg::ST_ERASE;
                    timer_next = spr_pkg::ERASE_CYC - spr_pkg::TIMER_ONE;
                end
            end
            spr_pkg::ST_ERASE,
            spr_pkg::ST_PROGRAM: begin
                if (timer_end) begin
                    state_next = spr_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = spr_pkg::ST_IDLE;
                timer_next = '0;
            end
        endcase
    end

    // State, busy flag and write enable latch.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_reg           <= spr_pkg::ST_IDLE;
            timer_reg           <= '0;
            o_write_in_progress <= 1'b0;
            wel_reg             <= 1'b0;
        end else if (i_clk_en) begin
            state_reg           <= state_next;
            timer_reg           <= timer_next;
            o_write_in_progress <= (state_next != spr_pkg::ST_IDLE);
            if (write_enable_cmd_go) begin
                wel_reg <= 1'b1;
            end else if (op_done) begin
                wel_reg <= 1'b0;
            end
        end
    end

    // Protection array, mode register and suspend refusal.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            mode_reg          <= spr_pkg::MODE_RESET;
            pend_reg          <= spr_pkg::MODE_RESET;
            bits_reg          <= '1;
            o_suspend_refused <= 1'b0;
        end else if (i_clk_en) begin
            o_suspend_refused <= i_suspend & erasing;
            if (prog_go) begin
                pend_reg <= {data_reg[7:0], data_reg[15:8]};
            end
            if (state_reg == spr_pkg::ST_PROGRAM && timer_end) begin
                mode_reg <= pend_reg;
            end
            if (state_reg == spr_pkg::ST_PREPROG && timer_end) begin
                bits_reg <= '0;
            end
            if (state_reg == spr_pkg::ST_ERASE && timer_end) begin
                bits_reg <= '1;
            end
        end
    end

    // ==========================================================
    // Transmit side: a 16-bit rotator shifted on falling edges.
    logic        tx_active_reg;
    logic [15:0] tx_reg;

    wire [7:0] status_byte = {6'h00, wel_reg, o_write_in_progress};
    wire hit_mode = (op_now == spr_pkg::OP_READ_MODE);
    wire hit_stat = (op_now == spr_pkg::OP_READ_STATUS);
    wire hit_lock = (op_now == spr_pkg::OP_READ_LOCK) & idle &
                    ~i_quad_mode;
    wire tx_load  = sck_rise & last_op_bit &
                    (hit_mode | hit_stat | hit_lock);
    // Eight-bit sources are doubled so the rotator repeats them.
    wire [15:0] tx_pattern =
        hit_mode ? {mode_reg[7:0], mode_reg[15:8]} :
        hit_lock ? {i_lock_reg, i_lock_reg} :
                   {status_byte, status_byte};

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            tx_active_reg <= 1'b0;
            tx_reg        <= 16'h0000;
            o_so          <= 1'b0;
            o_so_oe       <= 1'b0;
        end else if (i_clk_en) begin
            if (cs_rise || cs_fall) begin
                tx_active_reg <= 1'b0;
                o_so_oe       <= 1'b0;
            end else if (tx_load) begin
                tx_active_reg <= 1'b1;
                tx_reg        <= tx_pattern;
            end else if (sck_fall && tx_active_reg) begin
                o_so    <= tx_reg[15];
                o_so_oe <= 1'b1;
                tx_reg  <= {tx_reg[14:0], tx_reg[15]};
            end
        end
    end

    // ==========================================================
    // Registered status outputs.
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_write_enable_latch <= 1'b0;
            o_prot_mode          <= spr_pkg::MODE_RESET;
            o_prot_bits          <= '1;
            o_prot_entry         <= spr_pkg::ENTRY_UNPROT;
        end else if (i_clk_en) begin
            o_write_enable_latch <= wel_reg;
            o_prot_mode          <= mode_reg;
            o_prot_bits          <= bits_reg;
            o_prot_entry         <= entry_code(bits_reg[i_sel]);
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    a_erase_go_busy: assert property (
        i_clk_en && erase_go |=> state_reg == spr_pkg::ST_PREPROG
    ) else $error("erase did not start");
    a_preprog_then_erase: assert property (
        i_clk_en && state_reg == spr_pkg::ST_PREPROG && timer_end
        |=> state_reg == spr_pkg::ST_ERASE && bits_reg == '0
    ) else $error("pre-program phase did not lead to erase");
    a_erase_done_ones: assert property (
        i_clk_en && state_reg == spr_pkg::ST_ERASE && timer_end
        |=> &bits_reg && !wel_reg && idle
    ) else $error("erase end wrong");
    a_busy_flag_erase: assert property (
        i_clk_en && erase_go |=> ##1 o_write_in_progress
    ) else $error("busy flag not raised");
    a_no_latch_refuse: assert property (
        i_clk_en && end_ok && !wel_reg |=> idle && $stable(bits_reg)
        && $stable(pend_reg)
    ) else $error("write accepted without latch");
    a_suspend_refused: assert property (
        i_clk_en && i_suspend && erasing |=> o_suspend_refused
    ) else $error("suspend not refused");
    a_prog_bad_count: assert property (
        i_clk_en && end_ok && !op24 |=> state_reg != spr_pkg::ST_PROGRAM
    ) else $error("program started on wrong count");
    a_prog_value_order: assert property (
        i_clk_en && prog_go |=> pend_reg ==
        {$past(data_reg[7:0]), $past(data_reg[15:8])}
    ) else $error("program byte order wrong");
    a_prog_done_latch: assert property (
        i_clk_en && state_reg == spr_pkg::ST_PROGRAM && timer_end
        |=> !wel_reg && mode_reg == $past(pend_reg) ##1
        !o_write_in_progress
    ) else $error("program completion wrong");
    a_mode_read_order: assert property (
        i_clk_en && tx_load && hit_mode |=>
        tx_reg == {$past(mode_reg[7:0]), $past(mode_reg[15:8])}
    ) else $error("mode read order wrong");
    a_lock_not_busy: assert property (
        tx_load && (op_now == spr_pkg::OP_READ_LOCK)
        |-> idle && !i_quad_mode
    ) else $error("lock read while busy or quad");
    a_latch_held_erase: assert property (
        state_reg == spr_pkg::ST_ERASE |-> wel_reg
    ) else $error("latch cleared before erase end");

endmodule

//--- logic/spr_pkg.sv
// Shared constants for the sector protection register command block.
package spr_pkg;

    // ==========================================================
    // Opcodes, sampled most significant bit first.
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_READ_STATUS  = 8'h05;
    localparam logic [7:0] OP_ERASE_PROT   = 8'hE4;
    localparam logic [7:0] OP_READ_MODE    = 8'h2B;
    localparam logic [7:0] OP_PROG_MODE    = 8'h2F;
    localparam logic [7:0] OP_READ_LOCK    = 8'hA7;

    // ==========================================================
    // Frame lengths in rising clock edges.
    localparam logic [4:0] CNT_OPCODE = 5'h08;
    localparam logic [4:0] CNT_PROG   = 5'h18;
    localparam logic [4:0] CNT_MAX    = 5'h1F;

    // ==========================================================
    // Status byte layout and reset values.
    localparam int          SR_WIP_BIT   = 0;
    localparam int          SR_WEL_BIT   = 1;
    localparam logic [15:0] MODE_RESET   = 16'hFFFF;
    localparam logic [7:0]  ENTRY_PROT   = 8'h00;
    localparam logic [7:0]  ENTRY_UNPROT = 8'hFF;

    // ==========================================================
    // Internal operation times and their cycle counts.
    localparam int CLK_MHZ        = 250;
    localparam int PREPROG_NS     = 2000;
    localparam int ERASE_NS       = 4000;
    localparam int PROG_NS        = 1000;
    localparam int TIMER_W        = 12;
    localparam logic [TIMER_W-1:0] PREPROG_CYC =
        TIMER_W'((PREPROG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TIMER_W-1:0] ERASE_CYC =
        TIMER_W'((ERASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TIMER_W-1:0] PROG_CYC =
        TIMER_W'((PROG_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TIMER_W-1:0] TIMER_ONE = 12'h001;

    // ==========================================================
    // Internal operation states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_PREPROG = 4'b0010,
        ST_ERASE   = 4'b0100,
        ST_PROGRAM = 4'b1000
    } spr_state_t;

endpackage

//--- logic/spr_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps

module spr_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             i_clk_sys,  // System clock.
    input  wire logic             i_reset_n,  // Synchronous reset.
    input  wire logic             i_clk_en,   // Clock enable.
    input  wire logic [WIDTH-1:0] i_async,    // Asynchronous levels.
    input  wire logic [WIDTH-1:0] i_init,     // Reset level per bit.
    output logic      [WIDTH-1:0] o_sync      // Synchronised levels.
);

    // ==========================================================
    // First stage feeds only the second stage.
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            meta_reg <= i_init;
            o_sync   <= i_init;
        end else if (i_clk_en) begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule
